// ---- blit_pkg.sv ----
package blit_pkg;

    // ********************************
    // Geometry
    // ********************************
    localparam int WORD_W = 16;
    localparam int WORD_LOG = 4;
    localparam int BIT_ADDR_W = 32;
    localparam int WORD_ADDR_W = BIT_ADDR_W - WORD_LOG;
    localparam int DIM_W = 16;
    localparam int FIFO_DEPTH = 32;
    localparam int READS_PER_WORD = 3;

    // ********************************
    // Reset values
    // ********************************
    localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
    localparam logic [WORD_W-1:0] WORD_ONES = 16'hFFFF;
    localparam logic [WORD_ADDR_W-1:0] WADDR_ZERO = 28'h000_0000;
    localparam logic [BIT_ADDR_W-1:0] BADDR_ZERO = 32'h0000_0000;
    localparam logic [DIM_W-1:0] DIM_ZERO = 16'h0000;

    // ********************************
    // Logic functions
    // ********************************
    typedef enum logic [1:0]
    {
        OP_AND = 2'h0,
        OP_OR = 2'h1,
        OP_XOR = 2'h2,
        OP_COPY = 2'h3
    } logic_op_type;

    // Setup supplied by the controlling party
    typedef struct packed
    {
        logic [BIT_ADDR_W-1:0] frameOrigin;
        logic [DIM_W-1:0] srcX;
        logic [DIM_W-1:0] srcY;
        logic [DIM_W-1:0] dstX;
        logic [DIM_W-1:0] dstY;
        logic signed [DIM_W-1:0] srcPitch;
        logic signed [DIM_W-1:0] dstPitch;
        logic [DIM_W-1:0] width;
        logic [DIM_W-1:0] height;
        logic_op_type op;
        logic invertSrc;
        logic rightToLeft;
    } setup_type;

    // Word request towards frame memory
    typedef struct packed
    {
        logic write;
        logic [WORD_ADDR_W-1:0] addr;
        logic [WORD_W-1:0] data;
    } mem_req_type;

endpackage

// ---- bit_blit.sv ----
`timescale 1ns/10ps
`default_nettype none


// ********************************
// Read data FIFO
// ********************************
module blit_fifo
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wrPtr_r;
    logic [PW-1:0] rdPtr_r;
    logic [PW:0] count_r;
    logic push;
    logic pop;

    // Full and empty come straight from the occupancy count
    assign inReady = count_r != (PW+1)'(DEPTH);
    assign outValid = count_r != '0;
    assign outData = mem[rdPtr_r];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // Storage has no reset; only pointers and count need one
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wrPtr_r] <= inData;
        end
    end

    // Pointers and count
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (push)
            begin
                wrPtr_r <= (wrPtr_r == PW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
            end
            if (pop)
            begin
                rdPtr_r <= (rdPtr_r == PW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
            end
            count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule

// ********************************
// Block transfer engine
// ********************************
module bit_blit
#(
    parameter int FIFO_WORDS = blit_pkg::FIFO_DEPTH
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Control
    input wire logic start,
    input wire blit_pkg::setup_type setup,
    output logic busy,
    output logic done,
    // Memory requests
    output logic memValid,
    input wire logic memReady,
    output blit_pkg::mem_req_type memReq,
    // Memory read data
    input wire logic rdValid,
    output logic rdReady,
    input wire logic [blit_pkg::WORD_W-1:0] rdData
);
    import blit_pkg::*;

    typedef enum logic [7:0]
    {
        S_IDLE = 8'b0000_0001,
        S_LINE = 8'b0000_0010,
        S_RDLO = 8'b0000_0100,
        S_RDHI = 8'b0000_1000,
        S_RDDST = 8'b0001_0000,
        S_WAIT = 8'b0010_0000,
        S_WRITE = 8'b0100_0000,
        S_DONE = 8'b1000_0000
    } state_type;

    state_type state_r;
    setup_type cfg_r;
    logic [BIT_ADDR_W-1:0] lineSrc_r;
    logic [BIT_ADDR_W-1:0] lineDst_r;
    logic [DIM_W-1:0] linesLeft_r;
    logic [WORD_ADDR_W-1:0] dstWord_r;
    logic [WORD_ADDR_W-1:0] srcWord_r;
    logic [WORD_ADDR_W-1:0] firstWord_r;
    logic [WORD_ADDR_W-1:0] lastWord_r;
    logic [WORD_W-1:0] leftMask_r;
    logic [WORD_W-1:0] rightMask_r;
    logic [WORD_LOG-1:0] shift_r;
    logic [WORD_W-1:0] srcLo_r;
    logic [WORD_W-1:0] srcHi_r;
    logic [WORD_W-1:0] dstOld_r;
    logic [1:0] got_r;
    logic fifoValid;
    logic fifoPop;
    logic [WORD_W-1:0] fifoData;
    logic accepted;
    logic lastWord;
    logic [BIT_ADDR_W-1:0] startSrc;
    logic [BIT_ADDR_W-1:0] startDst;
    logic [BIT_ADDR_W-1:0] dstEnd;
    logic [BIT_ADDR_W-1:0] lineEnd;
    logic [BIT_ADDR_W-1:0] srcBit;
    logic [2*WORD_W-1:0] pair;
    logic [WORD_W-1:0] aligned;
    logic [WORD_W-1:0] combined;
    logic [WORD_W-1:0] mask;
    logic [WORD_W-1:0] merged;

    // Returned words queue here so read replies are never refused while the sequencer issues requests
    blit_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_WORDS)) readQueue
    (
        .clk(clk),
        .rstn(rstn),
        .inValid(rdValid),
        .inReady(rdReady),
        .inData(rdData),
        .outValid(fifoValid),
        .outReady(fifoPop),
        .outData(fifoData)
    );

    // Start addresses: origin + y*pitch*word + x, pitch sign picks up or down
    assign startSrc = setup.frameOrigin + BIT_ADDR_W'(setup.srcX)
        + BIT_ADDR_W'($signed({1'b0, setup.srcY}) * setup.srcPitch * WORD_W);
    assign startDst = setup.frameOrigin + BIT_ADDR_W'(setup.dstX)
        + BIT_ADDR_W'($signed({1'b0, setup.dstY}) * setup.dstPitch * WORD_W);
    assign dstEnd = startDst + BIT_ADDR_W'(setup.width) - 1'b1;
    assign lineEnd = lineDst_r + BIT_ADDR_W'(cfg_r.width) - 1'b1;

    // Source bit that lines up with bit 0 of the first destination word of the line;
    // its word may lie one below the source start word when the source offset is smaller
    assign srcBit = lineSrc_r - BIT_ADDR_W'(lineDst_r[WORD_LOG-1:0]);

    // Alignment, logic function and masking of one destination word
    always_comb
    begin
        pair = {srcHi_r, srcLo_r} >> shift_r;
        aligned = cfg_r.invertSrc ? ~pair[WORD_W-1:0] : pair[WORD_W-1:0];
        case (cfg_r.op)
            OP_AND: combined = aligned & dstOld_r;
            OP_OR: combined = aligned | dstOld_r;
            OP_XOR: combined = aligned ^ dstOld_r;
            default: combined = aligned;
        endcase
        mask = WORD_ONES;
        if (dstWord_r == firstWord_r)
        begin
            mask = mask & leftMask_r;
        end
        if (dstWord_r == lastWord_r)
        begin
            mask = mask & rightMask_r;
        end
        merged = (combined & mask) | (dstOld_r & ~mask);
    end

    assign accepted = memValid && memReady;
    assign lastWord = cfg_r.rightToLeft ? (dstWord_r == firstWord_r)
        : (dstWord_r == lastWord_r);
    // First source read waits until its address register has caught up
    assign memValid = ((state_r == S_RDLO) && (memReq.addr == srcWord_r)) || (state_r == S_RDHI)
        || (state_r == S_RDDST) || (state_r == S_WRITE);
    assign fifoPop = fifoValid && (got_r != 2'(READS_PER_WORD))
        && ((state_r == S_RDHI) || (state_r == S_RDDST) || (state_r == S_WAIT));
    assign busy = state_r != S_IDLE;

    // Sequencer: outer loop per line, inner loop per word
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r <= S_IDLE;
        end
        else
        begin
            case (state_r)
                S_IDLE: state_r <= start ? S_LINE : S_IDLE;
                S_LINE: state_r <= (linesLeft_r == DIM_ZERO) ? S_DONE : S_RDLO;
                S_RDLO: state_r <= accepted ? S_RDHI : S_RDLO;
                S_RDHI: state_r <= accepted ? S_RDDST : S_RDHI;
                S_RDDST: state_r <= accepted ? S_WAIT : S_RDDST;
                S_WAIT: state_r <= (got_r == 2'(READS_PER_WORD)) ? S_WRITE : S_WAIT;
                S_WRITE:
                begin
                    if (accepted)
                    begin
                        state_r <= lastWord ? S_LINE : S_RDLO;
                    end
                end
                S_DONE: state_r <= S_IDLE;
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // Setup capture, masks fixed once per transfer
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cfg_r <= '0;
            leftMask_r <= WORD_ONES;
            rightMask_r <= WORD_ONES;
            shift_r <= '0;
        end
        else if (state_r == S_IDLE && start)
        begin
            cfg_r <= setup;
            leftMask_r <= WORD_ONES << startDst[WORD_LOG-1:0];
            rightMask_r <= WORD_ONES >> (WORD_LOG'(WORD_W-1) - dstEnd[WORD_LOG-1:0]);
            shift_r <= startSrc[WORD_LOG-1:0] - startDst[WORD_LOG-1:0];
        end
    end

    // Outer loop addresses; pitch is whole words so masks stay valid
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            lineSrc_r <= BADDR_ZERO;
            lineDst_r <= BADDR_ZERO;
            linesLeft_r <= DIM_ZERO;
            firstWord_r <= WADDR_ZERO;
            lastWord_r <= WADDR_ZERO;
        end
        else if (state_r == S_IDLE && start)
        begin
            lineSrc_r <= startSrc;
            lineDst_r <= startDst;
            linesLeft_r <= setup.height;
        end
        else if (state_r == S_LINE && linesLeft_r != DIM_ZERO)
        begin
            firstWord_r <= lineDst_r[BIT_ADDR_W-1:WORD_LOG];
            lastWord_r <= lineEnd[BIT_ADDR_W-1:WORD_LOG];
            lineSrc_r <= lineSrc_r + BIT_ADDR_W'(cfg_r.srcPitch * WORD_W);
            lineDst_r <= lineDst_r + BIT_ADDR_W'(cfg_r.dstPitch * WORD_W);
            linesLeft_r <= linesLeft_r - 1'b1;
        end
    end

    // Inner loop word pointers, either direction
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dstWord_r <= WADDR_ZERO;
            srcWord_r <= WADDR_ZERO;
        end
        else if (state_r == S_RDLO && got_r == 2'd0 && !accepted && memReq.addr == WADDR_ZERO)
        begin
            dstWord_r <= dstWord_r;
        end
        else if (state_r == S_WRITE && accepted && !lastWord)
        begin
            dstWord_r <= cfg_r.rightToLeft ? dstWord_r - 1'b1 : dstWord_r + 1'b1;
            srcWord_r <= cfg_r.rightToLeft ? srcWord_r - 1'b1 : srcWord_r + 1'b1;
        end
        else if (state_r == S_LINE)
        begin
            dstWord_r <= cfg_r.rightToLeft ? lineEnd[BIT_ADDR_W-1:WORD_LOG]
                : lineDst_r[BIT_ADDR_W-1:WORD_LOG];
            srcWord_r <= cfg_r.rightToLeft
                ? srcBit[BIT_ADDR_W-1:WORD_LOG] + lineEnd[BIT_ADDR_W-1:WORD_LOG]
                    - lineDst_r[BIT_ADDR_W-1:WORD_LOG]
                : srcBit[BIT_ADDR_W-1:WORD_LOG];
        end
        else if (state_r == S_RDLO && got_r == 2'd0)
        begin
            srcWord_r <= srcWord_r;
        end
    end

    // Memory request word, whole aligned words only
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            memReq <= '0;
        end
        else
        begin
            case (state_r)
                S_RDLO:
                begin
                    memReq.write <= 1'b0;
                    memReq.addr <= accepted ? memReq.addr + 1'b1 : srcWord_r;
                end
                S_RDHI: memReq.addr <= accepted ? dstWord_r : memReq.addr;
                S_WAIT:
                begin
                    memReq.write <= got_r == 2'(READS_PER_WORD);
                    memReq.addr <= dstWord_r;
                    memReq.data <= merged;
                end
                S_WRITE: memReq.write <= accepted ? 1'b0 : memReq.write;
                default: memReq.write <= 1'b0;
            endcase
        end
    end

    // Collect low source, high source, then old destination word
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            got_r <= 2'd0;
            srcLo_r <= WORD_ZERO;
            srcHi_r <= WORD_ZERO;
            dstOld_r <= WORD_ZERO;
        end
        else if (state_r == S_WRITE && accepted)
        begin
            got_r <= 2'd0;
        end
        else if (fifoPop)
        begin
            got_r <= got_r + 1'b1;
            case (got_r)
                2'd0: srcLo_r <= fifoData;
                2'd1: srcHi_r <= fifoData;
                default: dstOld_r <= fifoData;
            endcase
        end
    end

    // Completion pulse after the final line is written
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            done <= 1'b0;
        end
        else
        begin
            done <= state_r == S_DONE;
        end
    end
endmodule

`default_nettype wire

// ---- bit_blit_props.sv ----
`timescale 1ns/10ps
`default_nettype none

// ****************
// Port checker
// ****************
module bit_blit_props
#(
    parameter int FIFO_WORDS = 32
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Control
    input wire logic start,
    input wire logic busy,
    input wire logic done,
    // Memory
    input wire logic memValid,
    input wire logic memReady,
    input wire blit_pkg::mem_req_type memReq,
    input wire logic rdValid,
    input wire logic rdReady
);
    import blit_pkg::*;
    logic [2:0] nRd_r;
    logic [2:0] nRet_r;

    // Reads issued since the last accepted write
    always_ff @(posedge clk or negedge rstn)
        if (!rstn)
            nRd_r <= 3'h0;
        else if (memValid && memReady)
            nRd_r <= memReq.write ? 3'h0 : nRd_r + 3'h1;

    // Words returned since the last accepted write
    always_ff @(posedge clk or negedge rstn)
        if (!rstn)
            nRet_r <= 3'h0;
        else if (memValid && memReady && memReq.write)
            nRet_r <= 3'h0;
        else if (rdValid && rdReady)
            nRet_r <= nRet_r + 3'h1;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_req_held: assert property (memValid && !memReady |=> memValid && $stable(memReq))
        else $error("request changed before acceptance");
    chk_start_busy: assert property (start && !busy |=> busy)
        else $error("start not taken");
    chk_idle_quiet: assert property (!busy |-> !memValid)
        else $error("memory request while idle");
    chk_done_idle: assert property (done |-> !busy && !memValid)
        else $error("done while still working");
    chk_done_pulse: assert property (done |=> !done)
        else $error("done longer than one cycle");
    chk_busy_done: assert property ($fell(busy) |-> done)
        else $error("busy ended without done");
    chk_three_reads: assert property (memValid && memReq.write |-> nRd_r == 3'h3)
        else $error("write not preceded by three reads");
    chk_reads_back: assert property (memValid && memReq.write |-> nRet_r == 3'h3)
        else $error("write before read data returned");

    cov_done: cover property (done);
    cov_stall: cover property (memValid && !memReady);
    cov_refused: cover property (start && busy);
endmodule

bind bit_blit bit_blit_props #(.FIFO_WORDS(FIFO_WORDS)) props (.clk(clk), .rstn(rstn),
    .start(start), .busy(busy), .done(done), .memValid(memValid), .memReady(memReady),
    .memReq(memReq), .rdValid(rdValid), .rdReady(rdReady));

`default_nettype wire

// ---- frame_memory.sv ----
`timescale 1ns/10ps
`default_nettype none

// ****************
// Frame memory model
// ****************
module frame_memory
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Pace: slow stalls requests and spaces replies
    input wire logic slow,
    // Word requests
    input wire logic memValid,
    output logic memReady,
    input wire blit_pkg::mem_req_type memReq,
    // Read replies
    output logic rdValid,
    input wire logic rdReady,
    output logic [15:0] rdData
);
    import blit_pkg::*;
    logic [WORD_W-1:0] words [0:1023];
    logic [WORD_W-1:0] pend [$];
    logic [1:0] tick;

    // Whole words only; address wraps at 1024 words
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            memReady <= 1'b0;
            rdValid <= 1'b0;
            rdData <= 16'h0000;
            tick <= 2'h0;
            pend.delete();
        end
        else
        begin
            tick <= tick + 2'h1;
            memReady <= !slow || tick[0];
            if (memValid && memReady && memReq.write)
                words[memReq.addr[9:0]] <= memReq.data;
            else if (memValid && memReady)
                pend.push_back(words[memReq.addr[9:0]]);
            if (rdValid && !rdReady)
                rdValid <= 1'b1;
            else if (pend.size() > 0 && (!slow || tick[1]))
            begin
                rdValid <= 1'b1;
                rdData <= pend.pop_front();
            end
            else
            begin
                rdValid <= 1'b0;
                rdData <= ~rdData; // No stale word on an idle bus
            end
        end
    end
endmodule

`default_nettype wire

// ---- bit_blit_bench.sv ----
`timescale 1ns/10ps
`default_nettype none

module bit_blit_bench;
    import blit_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic start = 1'b0;
    logic slow = 1'b0;
    setup_type setup = '0;
    logic busy, done, memValid, memReady, rdValid, rdReady;
    logic [15:0] rdData;
    mem_req_type memReq;
    logic [15:0] orig [0:1023];
    logic [15:0] expw [0:1023];
    int n_errors = 0;
    int comparisons = 0;

    // ****************
    // Clock and parts
    // ****************
    always #25 clk = ~clk;

    bit_blit #(.FIFO_WORDS(32)) DUT (.clk(clk), .rstn(rstn), .start(start), .setup(setup),
        .busy(busy), .done(done), .memValid(memValid), .memReady(memReady), .memReq(memReq),
        .rdValid(rdValid), .rdReady(rdReady), .rdData(rdData));
    frame_memory mem (.clk(clk), .rstn(rstn), .slow(slow), .memValid(memValid),
        .memReady(memReady), .memReq(memReq), .rdValid(rdValid), .rdReady(rdReady),
        .rdData(rdData));

    // ****************
    // Helpers
    // ****************
    task automatic check(input string what, input logic [31:0] expv, input logic [31:0] got);
        comparisons++;
        if (got !== expv)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, expv, got);
        end
    endtask

    task automatic print_verdict;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Pixel bit address; pitch counts words per line
    function automatic int pix(input int x, input int y, input logic signed [15:0] p);
        return (32'h0000_2000 + y * int'(p) * 16 + x) & 32'h0000_3FFF;
    endfunction

    function automatic setup_type mk(input int op, input int inv, input int r2l, input int sx,
        input int sy, input int dx, input int dy, input int p, input int w, input int h);
        mk = '{32'h0000_2000, 16'(sx), 16'(sy), 16'(dx), 16'(dy), 16'(p), 16'(p), 16'(w),
            16'(h), logic_op_type'(op), 1'(inv), 1'(r2l)};
    endfunction

    // Fill memory, predict per pixel from the old image, run, compare every word
    task automatic blit(input setup_type s, input logic sl, input logic poke);
        int sb, db, cyc;
        logic a, b, r;
        for (int i = 0; i < 1024; i++)
        begin
            orig[i] = 16'(i * 32'h0000_9E37 + comparisons);
            expw[i] = orig[i];
            mem.words[i] = orig[i];
        end
        for (int j = 0; j < int'(s.height); j++)
            for (int i = 0; i < int'(s.width); i++)
            begin
                sb = pix(int'(s.srcX) + i, int'(s.srcY) + j, s.srcPitch);
                db = pix(int'(s.dstX) + i, int'(s.dstY) + j, s.dstPitch);
                a = orig[sb[13:4]][sb[3:0]] ^ s.invertSrc;
                b = orig[db[13:4]][db[3:0]];
                case (s.op)
                    OP_AND: r = a & b;
                    OP_OR: r = a | b;
                    OP_XOR: r = a ^ b;
                    default: r = a;
                endcase
                expw[db[13:4]][db[3:0]] = r;
            end
        slow = sl;
        @(posedge clk);
        #2 setup = s;
        start = 1'b1;
        @(posedge clk);
        #2 start = 1'b0;
        check("busy", 1, busy);
        cyc = 0;
        // A poke restarts with a moving setup that must be ignored
        while (done !== 1'b1 && cyc < 5000)
        begin
            @(posedge clk);
            #2 cyc++;
            start = poke && cyc == 5;
            setup.dstX = s.dstX + 16'(poke ? cyc : 0);
        end
        check("done", 1, done);
        check("busy", 0, busy);
        for (int i = 0; i < 1024; i++)
            check("word", expw[i], mem.words[i]);
    endtask

    // ****************
    // Tests
    // ****************
    initial
    begin
        repeat (5) @(posedge clk);
        #2 rstn = 1'b1;
        check("busy", 0, busy);
        check("memValid", 0, memValid);
        check("rdReady", 1, rdReady);
        // Every function, both source senses, both word orders
        for (int k = 0; k < 8; k++)
            blit(mk(k % 4, k / 4, k % 2 ^ k / 4, 1 + k, 2, 4 + 3 * k, 10, 4, 19 + k, 6),
                1'(k / 2), 1'b0);
        blit(mk(2, 0, 0, 3, 2, 6, 12, -4, 5, 3), 1'b0, 1'b0);
        blit(mk(1, 1, 1, 9, 2, 15, 12, -4, 40, 4), 1'b1, 1'b0);
        blit(mk(3, 0, 1, 3, 20, 8, 20, 4, 30, 2), 1'b0, 1'b0);
        blit(mk(1, 0, 0, 5, 30, 2, 29, -4, 33, 4), 1'b1, 1'b0);
        blit(mk(3, 0, 0, 1, 2, 4, 10, 4, 19, 0), 1'b0, 1'b0);
        blit(mk(0, 0, 0, 1, 2, 4, 10, 4, 19, 6), 1'b1, 1'b1);
        blit(mk(1, 0, 0, 0, 40, 0, 45, 4, 16, 1), 1'b0, 1'b0);
        // Read buffer not full (rdReady high) and engine quiet after all transfers
        repeat (4) @(posedge clk);
        #2 check("rdReady", 1, rdReady);
        check("memValid", 0, memValid);
        check("busy", 0, busy);
        print_verdict();
    end

    // Watchdog: the tests need well under 20000 cycles
    initial
    begin
        #1_000_000;
        n_errors++;
        $display("unexpected timeout");
        print_verdict();
    end
endmodule

`default_nettype wire
